// >>> hw/srs_supervisor.sv
// Purpose: reset supervisor, watchdog, low-voltage flag, write inhibit
// Assumes: supply and sense comparators give digital levels
// Notes: reset pins are open drain; oe high means pulling
`timescale 1ns/1ps
module srs_supervisor #(
  parameter logic HAS_WATCHDOG = 1'b1,
  parameter longint HOLD_CYC = srs_pkg::RST_HOLD_CYC,
  parameter longint WDOG_CYC = srs_pkg::WDOG_TOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supplyOk,
  input wire logic senseAboveRef,
  input wire logic watchdog_toggle_in,
  input wire logic resetLowPinIn,
  output logic resetLowPinOut,
  output logic resetLowPinOe,
  output logic resetHighPinOut,
  output logic resetHighPinOe,
  output logic lowFlagOut,
  output logic lowFlagOe,
  output logic writeInhibit
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic supplyOkSync;
  logic senseSync;
  logic toggleSync;
  logic resetPinSync;

  srs_sync #(.RESET_VAL(1'b0)) uSupply (
    .clk(clk), .rst_n(rst_n), .asyncIn(supplyOk), .syncOut(supplyOkSync));
  srs_sync #(.RESET_VAL(1'b0)) uSense (
    .clk(clk), .rst_n(rst_n), .asyncIn(senseAboveRef),
    .syncOut(senseSync));
  srs_sync #(.RESET_VAL(1'b0)) uToggle (
    .clk(clk), .rst_n(rst_n), .asyncIn(watchdog_toggle_in),
    .syncOut(toggleSync));
  srs_sync #(.RESET_VAL(1'b1)) uResetPin (
    .clk(clk), .rst_n(rst_n), .asyncIn(resetLowPinIn),
    .syncOut(resetPinSync));

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RESET,
    ST_HOLD,
    ST_RUN
  } srs_phase_t;

  typedef struct packed {
    srs_phase_t phase;
    logic [srs_pkg::CNT_W-1:0] holdCnt;
    logic [srs_pkg::CNT_W-1:0] wdogCnt;
    logic toggleLast;
    logic resetAct;
    logic lowFlagAct;
    logic inhibit;
    logic [1:0] pinSettle;
  } srs_state_t;

  srs_state_t state_reg;
  srs_state_t state_next;

  localparam logic [srs_pkg::CNT_W-1:0] HOLD_LAST =
    srs_pkg::CNT_W'(HOLD_CYC - 1);
  localparam logic [srs_pkg::CNT_W-1:0] WDOG_LAST =
    srs_pkg::CNT_W'(WDOG_CYC - 1);
  localparam logic [1:0] PIN_SETTLE = 2'(srs_pkg::SYNC_STAGES);

  // Own drive of the reset pin is masked so it is not seen as manual
  // Synced pin lags release by two edges, so wait that out first
  logic manualReset;
  assign manualReset = !resetPinSync && !state_reg.resetAct &&
    (state_reg.pinSettle == '0);

  always_comb begin
    state_next = state_reg;
    state_next.toggleLast = toggleSync;
    state_next.lowFlagAct = !senseSync;
    state_next.inhibit = !supplyOkSync;
    case (state_reg.phase)
      ST_RESET: begin
        state_next.resetAct = 1'b1;
        state_next.pinSettle = PIN_SETTLE;
        state_next.holdCnt = '0;
        state_next.wdogCnt = '0;
        if (supplyOkSync) begin
          state_next.phase = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_next.resetAct = 1'b1;
        state_next.pinSettle = PIN_SETTLE;
        state_next.wdogCnt = '0;
        if (!supplyOkSync) begin
          state_next.phase = ST_RESET;
        end else if (state_reg.holdCnt == HOLD_LAST) begin
          state_next.phase = ST_RUN;
          state_next.resetAct = 1'b0;
          state_next.holdCnt = '0;
        end else begin
          state_next.holdCnt = state_reg.holdCnt + 1'b1;
        end
      end
      ST_RUN: begin
        state_next.resetAct = 1'b0;
        if (state_reg.pinSettle != '0) begin
          state_next.pinSettle = state_reg.pinSettle - 2'h1;
        end
        if (!supplyOkSync) begin
          state_next.phase = ST_RESET;
          state_next.resetAct = 1'b1;
          state_next.wdogCnt = '0;
        end else if (manualReset) begin
          state_next.phase = ST_HOLD;
          state_next.resetAct = 1'b1;
          state_next.holdCnt = '0;
          state_next.wdogCnt = '0;
        end else if (HAS_WATCHDOG) begin
          if (toggleSync != state_reg.toggleLast) begin
            state_next.wdogCnt = '0;
          end else if (state_reg.wdogCnt == WDOG_LAST) begin
            state_next.phase = ST_HOLD;
            state_next.resetAct = 1'b1;
            state_next.holdCnt = '0;
            state_next.wdogCnt = '0;
          end else begin
            state_next.wdogCnt = state_reg.wdogCnt + 1'b1;
          end
        end
      end
      default: begin
        state_next.phase = ST_RESET;
        state_next.resetAct = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.phase <= ST_RESET;
      state_reg.holdCnt <= '0;
      state_reg.wdogCnt <= '0;
      state_reg.toggleLast <= 1'b0;
      state_reg.resetAct <= 1'b1;
      state_reg.lowFlagAct <= 1'b1;
      state_reg.inhibit <= 1'b1;
      state_reg.pinSettle <= PIN_SETTLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign resetLowPinOut = srs_pkg::RST_ACTIVE_LOW;
  assign resetLowPinOe = state_reg.resetAct;
  assign resetHighPinOut = srs_pkg::RST_ACTIVE_HIGH;
  // Watchdog part leaves the high reset undriven
  assign resetHighPinOe = state_reg.resetAct && !HAS_WATCHDOG;
  assign lowFlagOut = 1'b0;
  assign lowFlagOe = state_reg.lowFlagAct;
  assign writeInhibit = state_reg.inhibit;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence supplyDrop;
    $fell(supplyOkSync);
  endsequence

  chk_low_supply_rst: assert property (
    @(posedge clk) disable iff (!rst_n)
    !supplyOkSync |=> resetLowPinOe)
    else $error("reset not driven while supply low");

  chk_hold_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg.phase == ST_HOLD && state_reg.holdCnt == HOLD_LAST &&
     supplyOkSync) |=> (!resetLowPinOe && state_reg.phase == ST_RUN))
    else $error("reset not released after hold");

  chk_hold_kept: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg.phase == ST_HOLD) |-> resetLowPinOe)
    else $error("reset released during hold");

  chk_manual_rst: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg.phase == ST_RUN && supplyOkSync && manualReset)
    |=> (resetLowPinOe && state_reg.holdCnt == '0))
    else $error("manual reset ignored");

  chk_wdog_expire: assert property (
    @(posedge clk) disable iff (!rst_n)
    (HAS_WATCHDOG && state_reg.phase == ST_RUN && supplyOkSync &&
     !manualReset && state_reg.wdogCnt == WDOG_LAST &&
     toggleSync == state_reg.toggleLast) |=> resetLowPinOe)
    else $error("watchdog timeout did not reset");

  chk_wdog_kick: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg.phase == ST_RUN && toggleSync != state_reg.toggleLast)
    |=> state_reg.wdogCnt == '0)
    else $error("toggle edge did not restart watchdog");

  chk_low_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    !senseSync |=> lowFlagOe)
    else $error("low flag not driven");

  chk_flag_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    senseSync |=> !lowFlagOe)
    else $error("low flag not released");

  chk_write_block: assert property (
    @(posedge clk) disable iff (!rst_n)
    supplyDrop |=> writeInhibit [*2])
    else $error("writes not inhibited on supply drop");

  chk_high_variant: assert property (
    @(posedge clk) disable iff (!rst_n)
    HAS_WATCHDOG |-> !resetHighPinOe)
    else $error("high reset driven in watchdog variant");

  chk_wdog_restart: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg.phase == ST_HOLD) |-> state_reg.wdogCnt == '0)
    else $error("watchdog count not restarted by reset");
endmodule // srs_supervisor

// >>> hw/srs_sync.sv
// Purpose: two-flop synchroniser for one asynchronous level
// Assumes: input is a slow level from a pin or comparator
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module srs_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  typedef struct packed {
    logic meta;
    logic stable;
  } srs_sync_t;

  srs_sync_t state_reg;
  srs_sync_t state_next;

  always_comb begin
    state_next.meta = asyncIn;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= {RESET_VAL, RESET_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stable;
endmodule // srs_sync

// >>> inc/srs_pkg.sv
// Purpose: constants for the supply reset supervisor with watchdog
// Assumes: 200 MHz system clock, analogue comparators outside
// Notes: long counts are top-level parameters so sims can shorten them
//
// What this block does
// - Assert reset while supply is low; both resets only without the watchdog
// - Hold reset 200 ms after supply recovers
// - Low forced reset pin starts manual reset
// - Toggle edges restart watchdog; 1.6 s timeout resets
// - Low flag follows auxiliary sense comparator
// - Block memory writes while supply is low
// - Watchdog variant drives only active-low reset
package srs_pkg;
  localparam longint CLK_HZ = 200000000;
  localparam longint RST_HOLD_MS = 200;
  localparam longint RST_HOLD_CYC = RST_HOLD_MS * CLK_HZ / 1000;
  localparam longint WDOG_TOUT_MS = 1600;
  localparam longint WDOG_TOUT_CYC = WDOG_TOUT_MS * CLK_HZ / 1000;
  localparam int CNT_W = 32;
  localparam int SYNC_STAGES = 2;
  localparam logic RST_ACTIVE_LOW = 1'b0;
  localparam logic RST_ACTIVE_HIGH = 1'b1;
endpackage

// >>> test/srs_host_model.sv
// Purpose: host controller model on the reset and watchdog side
// Assumes: reset wire has a pull-up; either party may pull it low
// Notes: kicks stop only when the bench clears kickEn
`timescale 1ns/1ps
module srs_host_model (
  input wire logic clk,
  input wire logic kickEn,
  input wire logic pushBtn,
  input wire logic devPullOe,
  output logic toggleOut,
  output logic resetWire
);
  logic [3:0] div;
  initial begin
    toggleOut = 1'b0;
    div = 4'h0;
  end
  // Kick every 16 cycles, well inside the shortened timeout
  // Rising edge with nonblocking update, so the device never races it
  always @(posedge clk) begin
    div <= div + 4'h1;
    if (kickEn && div == 4'hF) begin
      toggleOut <= !toggleOut;
    end
  end
  // Pulled up; low if the device or the push button pulls
  assign resetWire = !(devPullOe || pushBtn);
endmodule // srs_host_model

// >>> test/tb_top.sv
// Purpose: self-checking bench for the supply reset supervisor
// Assumes: shortened hold and watchdog counts
// Notes: latency windows allow for the input synchronisers
`timescale 1ns/1ps
module tb_top;
  localparam longint HOLD = 20;
  localparam longint WDOG = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supplyOk = 1'b0;
  logic senseAboveRef = 1'b1;
  logic kickEn = 1'b1;
  logic pushBtn = 1'b0;
  logic toggle, resetWire, rLowOut, rLowOe, rHighOut, rHighOe;
  logic flagOut, flagOe, wInh;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  always #2.5 clk = !clk;
  srs_host_model i_srs_host_model (.clk(clk), .kickEn(kickEn),
    .pushBtn(pushBtn), .devPullOe(rLowOe), .toggleOut(toggle),
    .resetWire(resetWire));
  srs_supervisor #(.HAS_WATCHDOG(1'b1), .HOLD_CYC(HOLD), .WDOG_CYC(WDOG))
    i_srs_supervisor (.clk(clk), .rst_n(rst_n), .supplyOk(supplyOk),
    .senseAboveRef(senseAboveRef), .watchdog_toggle_in(toggle),
    .resetLowPinIn(resetWire), .resetLowPinOut(rLowOut),
    .resetLowPinOe(rLowOe), .resetHighPinOut(rHighOut),
    .resetHighPinOe(rHighOe), .lowFlagOut(flagOut), .lowFlagOe(flagOe),
    .writeInhibit(wInh));
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Bounded wait so a stuck pull cannot hang the run
  task automatic wait_oe(input logic lvl, input int lim, output int k);
    k = 0;
    while (rLowOe !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic end_of_test();
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_power_up();
    cyc(2);
    chk(rLowOe, 1'b1);
    chk(rLowOut, 1'b0);
    chk(rHighOut, 1'b1);
    chk(wInh, 1'b1);
    supplyOk = 1'b1;
    wait_oe(1'b0, 60, n);
    chk_n(n, HOLD + 2, HOLD + 6);
    chk(wInh, 1'b0);
    chk(rHighOe, 1'b0);
    cyc(8);
    chk(rLowOe, 1'b0);
    $display("test power_up done");
  endtask
  task automatic t_brownout();
    supplyOk = 1'b0;
    wait_oe(1'b1, 10, n);
    chk_n(n, 2, 4);
    chk(wInh, 1'b1);
    chk(rHighOe, 1'b0);
    cyc(8);
    supplyOk = 1'b1;
    wait_oe(1'b0, 60, n);
    chk_n(n, HOLD + 2, HOLD + 6);
    $display("test brownout done");
  endtask
  task automatic t_manual();
    pushBtn = 1'b1;
    cyc(2);
    pushBtn = 1'b0;
    wait_oe(1'b1, 10, n);
    chk_n(n, 0, 3);
    wait_oe(1'b0, 60, n);
    chk_n(n, HOLD - 2, HOLD + 3);
    cyc(8);
    chk(rLowOe, 1'b0);
    $display("test manual done");
  endtask
  task automatic t_watchdog();
    kickEn = 1'b0;
    wait_oe(1'b1, 200, n);
    chk_n(n, WDOG - 20, WDOG + 4);
    wait_oe(1'b0, 60, n);
    chk_n(n, HOLD - 1, HOLD + 3);
    wait_oe(1'b1, 200, n);
    chk_n(n, WDOG - 2, WDOG + 4);
    kickEn = 1'b1;
    wait_oe(1'b0, 60, n);
    chk_n(n, HOLD - 1, HOLD + 3);
    cyc(3 * WDOG);
    chk(rLowOe, 1'b0);
    $display("test watchdog done");
  endtask
  task automatic t_low_flag();
    senseAboveRef = 1'b0;
    cyc(4);
    chk(flagOe, 1'b1);
    chk(flagOut, 1'b0);
    senseAboveRef = 1'b1;
    cyc(4);
    chk(flagOe, 1'b0);
    $display("test low_flag done");
  endtask
  // ----------------------------
  // Main sequence and watchdog
  // ----------------------------
  initial begin
    cyc(5);
    rst_n = 1'b1;
    t_power_up();
    t_brownout();
    t_manual();
    t_watchdog();
    t_low_flag();
    end_of_test();
  end
  initial begin
    #20000;
    err_total++;
    end_of_test();
  end
endmodule // tb_top
